// [byte_fifo.sv]
// Small FIFO with registered read data
`timescale 1ns/1ns
module byte_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
) (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [WIDTH-1:0]             in_data,
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [WIDTH-1:0]                  out_data,
	output logic [$clog2(DEPTH+2)-1:0]        level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [CW-1:0]    count;
	logic             push;
	logic             pop;
	// Full only when the array is full; the output stage adds one slot
	assign in_ready = (count != CW'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);
	assign level = ($clog2(DEPTH+2))'(count) + ($clog2(DEPTH+2))'(out_valid);
	// Array write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end
	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
			count <= count + CW'(push) - CW'(pop);
		end
	end
	// Output register, read data straight from a flop
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data <= mem[rp];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end
endmodule : byte_fifo

// [modem_port_consts.svh]
// Register offsets, reset values and timing constants of the modem port
`ifndef MODEM_PORT_CONSTS_SVH
`define MODEM_PORT_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MP_REG_CTRL      8'h00
`define MP_REG_SYN       8'h04
`define MP_REG_MSG_LEN   8'h08
`define MP_REG_STATUS    8'h0C
`define MP_REG_LOSS      8'h10
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MP_CTRL_W        5
`define MP_STAT_LVL_POS  8
`define MP_CTRL_RESET    5'h00
`define MP_SYN_RESET     8'h16
`define MP_MSG_LEN_RESET 8'h10
// ----------------------------------------
// Timing
// ----------------------------------------
`define MP_CLK_NS        8
`define MP_BIT_HALF_NS   40
`define MP_FIFO_DEPTH    8
`endif

// [modem_port_pkg.sv]
// Types shared by the modem port and its bench
package modem_port_pkg;
	// Control word written by software
	typedef struct packed {
		logic [1:0] streams_m1;
		logic       long_haul_host_protocol;
		logic       guaranteed;
		logic       syn_insert;
	} ctrl_t;
	// One byte of a message with its framing
	typedef struct packed {
		logic       last;
		logic [1:0] stream;
		logic [7:0] data;
	} net_byte_t;
	// Input framing states
	typedef enum logic [1:0] {
		HUNT = 2'b00,
		IDLE = 2'b01,
		MSG  = 2'b10
	} in_state_t;
endpackage : modem_port_pkg

// [modem_user_model.sv]
// Attached system model: sends and collects bytes on the modem bit clocks
`timescale 1ns/1ns
module modem_user_model #(
	parameter logic [7:0] SYN = 8'h16
) (
	input  wire logic sys_in_clk,
	output logic      sys_data_in,
	input  wire logic sys_out_clk,
	input  wire logic sys_data_out
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] cur;
	logic [7:0] shf;
	int         tcnt;
	int         rcnt;
	// Line starts idle on fill, first bit already presented
	initial
	begin
		cur = SYN;
		tcnt = 1;
		rcnt = 0;
		sys_data_in = SYN[0];
	end
	// pause tolerated
	// Bits move only on clock edges, so a held clock just waits
	always @(negedge sys_in_clk)
	begin
		if (tcnt == 0)
			cur = (tx_q.size() != 0) ? tx_q.pop_front() : SYN;
		sys_data_in <= cur[tcnt[2:0]];
		tcnt = (tcnt + 1) % 8;
	end
	// Collect output bytes, LSB first
	always @(posedge sys_out_clk)
	begin
		shf = {sys_data_out, shf[7:1]};
		rcnt++;
		if (rcnt == 8)
		begin
			rx_q.push_back(shf);
			rcnt = 0;
		end
	end
endmodule : modem_user_model

// [sync_bitstream_modem_port.sv]
// Synchronous modem emulating port: framing, SYN handling and bit clocks
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "modem_port_consts.svh"
module sync_bitstream_modem_port
	import modem_port_pkg::*;
#(
	parameter int HALF_CYCLES = (`MP_BIT_HALF_NS + `MP_CLK_NS - 1) / `MP_CLK_NS,
	parameter int FIFO_DEPTH  = `MP_FIFO_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic             sys_in_clk,
	input  wire logic        sys_data_in,
	output logic             sys_out_clk,
	output logic             sys_data_out,
	output net_byte_t        net_tx,
	output logic             net_tx_valid,
	input  wire logic        net_tx_ready,
	input  wire net_byte_t   net_rx,
	input  wire logic        net_rx_valid,
	output logic             net_rx_ready,
	output logic             long_haul_host_protocol
);
	localparam int LW = $clog2(FIFO_DEPTH+2);
	localparam int DW = $clog2(HALF_CYCLES+1);
	ctrl_t           ctrl;
	logic [7:0]      syn_char;
	logic [7:0]      msg_len;
	logic [15:0]     loss_count;
	logic [DW-1:0]   div_count;
	logic            half_tick;
	logic [1:0]      bit_clk;
	logic [1:0]      rise;
	logic [1:0]      suspend;
	logic            din_meta;
	logic            din_sync;
	in_state_t       in_state;
	logic [7:0]      in_shift;
	logic [7:0]      next_in_shift;
	logic [2:0]      in_bitcnt;
	logic [7:0]      msg_count;
	logic [1:0]      stream;
	logic            char_done;
	logic            push;
	net_byte_t       push_item;
	logic            fifo_in_ready;
	logic            fifo_out_valid;
	net_byte_t       fifo_out;
	logic            fifo_pop;
	logic [LW-1:0]   fifo_level;
	logic            in_suspend;
	logic [7:0]      out_shift;
	logic [3:0]      out_bits;
	logic            hold_valid;
	logic [7:0]      hold_data;
	logic            out_load;
	logic            next_hold_valid;
	logic [31:0]     next_rdata;
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Software writes; a loss counter clear in the same cycle as a new loss leaves the count at one
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl <= ctrl_t'(`MP_CTRL_RESET);
			syn_char <= `MP_SYN_RESET;
			msg_len <= `MP_MSG_LEN_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `MP_REG_CTRL)
				ctrl <= ctrl_t'(reg_wdata[`MP_CTRL_W-1:0]);
			if (reg_addr == `MP_REG_SYN)
				syn_char <= reg_wdata[7:0];
			if (reg_addr == `MP_REG_MSG_LEN)
				msg_len <= reg_wdata[7:0];
		end
	end
	// Read mux, unmapped offsets read zero
	always_comb
	begin
		unique case (reg_addr)
			`MP_REG_CTRL:    next_rdata = 32'(ctrl);
			`MP_REG_SYN:     next_rdata = 32'(syn_char);
			`MP_REG_MSG_LEN: next_rdata = 32'(msg_len);
			`MP_REG_STATUS:  next_rdata = (32'(fifo_level) << `MP_STAT_LVL_POS)
				| 32'({in_state == MSG, suspend[1], suspend[0], in_state != HUNT});
			`MP_REG_LOSS:    next_rdata = 32'(loss_count);
			default:         next_rdata = 32'h00000000;
		endcase
	end
	// Read data stands the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			long_haul_host_protocol <= 1'b0;
		else
			long_haul_host_protocol <= ctrl.long_haul_host_protocol;
	end
	// ----------------------------------------
	// Bit clock generation
	// ----------------------------------------
	// Half bit divider shared by both directions
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			div_count <= '0;
			half_tick <= 1'b0;
		end
		else
		begin
			half_tick <= (div_count == DW'(HALF_CYCLES-1));
			div_count <= (div_count == DW'(HALF_CYCLES-1)) ? '0 : div_count + 1'b1;
		end
	end
	// guaranteed mode always pauses rather than losing input
	assign in_suspend = !fifo_in_ready && (ctrl.guaranteed || !ctrl.syn_insert);
	assign suspend = {out_bits == 4'h0, in_suspend};
	// both clocks made here; pauses only hold the clock low
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_bitclk
			// a pause simply stretches the low phase
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					bit_clk[gi] <= 1'b0;
					rise[gi] <= 1'b0;
				end
				else
				begin
					rise[gi] <= half_tick && !bit_clk[gi] && !suspend[gi];
					if (half_tick && (bit_clk[gi] || !suspend[gi]))
						bit_clk[gi] <= !bit_clk[gi];
				end
			end
		end
	endgenerate
	assign sys_in_clk = bit_clk[0];
	assign sys_out_clk = bit_clk[1];
	// ----------------------------------------
	// Input path
	// ----------------------------------------
	// Pin synchroniser
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			din_meta <= 1'b0;
			din_sync <= 1'b0;
		end
		else
		begin
			din_meta <= sys_data_in;
			din_sync <= din_meta;
		end
	end
	// Least significant bit arrives first
	assign next_in_shift = {din_sync, in_shift[7:1]};
	assign char_done = rise[0] && (in_state != HUNT) && (in_bitcnt == 3'h7);
	// a SYN seen between messages is never pushed
	assign push = char_done && !(in_state == IDLE && next_in_shift == syn_char);
	assign push_item = '{last: (in_state == IDLE) ? (msg_len == 8'h01)
		: (msg_count + 8'h01 == msg_len), stream: stream, data: next_in_shift};
	// Character framing and message boundaries
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			in_state <= HUNT;
			in_shift <= 8'h00;
			in_bitcnt <= 3'h0;
			msg_count <= 8'h00;
		end
		else if (rise[0])
		begin
			in_shift <= next_in_shift;
			in_bitcnt <= in_bitcnt + 3'h1;
			unique case (in_state)
				HUNT:
				begin
					// bitwise search aligns the character framing
					in_bitcnt <= 3'h0;
					// first fill character gives the framing
					if (next_in_shift == syn_char)
						in_state <= IDLE;
				end
				IDLE:
				begin
					if (push)
					begin
						msg_count <= 8'h01;
						if (!push_item.last)
							in_state <= MSG;
					end
				end
				MSG:
				begin
					if (push)
					begin
						msg_count <= msg_count + 8'h01;
						if (push_item.last)
							in_state <= IDLE;
					end
				end
				default:
					in_state <= HUNT;
			endcase
		end
	end
	// successive messages rotate over the configured streams
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			stream <= 2'h0;
		else if (push && push_item.last)
			stream <= (stream >= ctrl.streams_m1) ? 2'h0 : stream + 2'h1;
	end
	// fixed delay mode counts bytes lost to a full buffer
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			loss_count <= 16'h0000;
		else if (push && !fifo_in_ready)
			loss_count <= (reg_wr && reg_addr == `MP_REG_LOSS) ? 16'h0001 : loss_count + 16'h0001;
		else if (reg_wr && reg_addr == `MP_REG_LOSS)
			loss_count <= 16'h0000;
	end
	byte_fifo #(
		.WIDTH ($bits(net_byte_t)),
		.DEPTH (FIFO_DEPTH)
	) u_in_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_item),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out),
		.level     (fifo_level)
	);
	// Network output register, stalls the buffer when the network stalls
	assign fifo_pop = !net_tx_valid || net_tx_ready;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			net_tx_valid <= 1'b0;
			net_tx <= '0;
		end
		else if (fifo_pop)
		begin
			net_tx_valid <= fifo_out_valid;
			net_tx <= fifo_out;
		end
	end
	// ----------------------------------------
	// Output path
	// ----------------------------------------
	// One byte holding register; ready is only high while it is empty
	assign out_load = (out_bits == 4'h0) && (hold_valid || ctrl.syn_insert);
	assign next_hold_valid = (net_rx_valid && net_rx_ready) || (hold_valid && !out_load);
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hold_valid <= 1'b0;
			hold_data <= 8'h00;
			net_rx_ready <= 1'b0;
		end
		else
		begin
			hold_valid <= next_hold_valid;
			net_rx_ready <= !next_hold_valid;
			if (net_rx_valid && net_rx_ready)
				hold_data <= net_rx.data;
		end
	end
	// bytes leave in arrival order, least significant bit first
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_shift <= 8'h00;
			out_bits <= 4'h0;
			sys_data_out <= 1'b0;
		end
		else if (out_load)
		begin
			// fill with SYN when nothing waits
			out_shift <= hold_valid ? hold_data : syn_char;
			sys_data_out <= hold_valid ? hold_data[0] : syn_char[0];
			out_bits <= 4'h8;
		end
		else if (half_tick && bit_clk[1] && out_bits != 4'h0)
		begin
			out_shift <= {1'b0, out_shift[7:1]};
			sys_data_out <= out_shift[1];
			// starving leaves out_bits at zero, holding the clock
			out_bits <= out_bits - 4'h1;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking chk_clk @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_in_clk_pause: assert property ($rose(sys_in_clk) |-> !$past(in_suspend))
		else $error("input clock rose while buffer full");
	a_out_clk_pause: assert property ($rose(sys_out_clk) |-> $past(out_bits) != 4'h0)
		else $error("output clock rose with no data");
	a_syn_fill: assert property (out_bits == 4'h0 && !hold_valid && ctrl.syn_insert
		|=> out_bits == 4'h8 && out_shift == $past(syn_char)) else $error("SYN fill not loaded");
	a_syn_drop: assert property (char_done && in_state == IDLE && next_in_shift == syn_char
		|-> !push ##1 in_state == IDLE && msg_count == $past(msg_count))
		else $error("idle SYN pushed");
	a_frame_lock: assert property (rise[0] && in_state == HUNT && next_in_shift == syn_char
		|=> in_state == IDLE && in_bitcnt == 3'h0) else $error("framing not locked on fill");
	a_msg_end: assert property (push && push_item.last && in_state == MSG
		|=> in_state == IDLE) else $error("message did not end");
	a_loss_count: assert property (push && !fifo_in_ready && !reg_wr
		|=> loss_count == $past(loss_count) + 16'h0001) else $error("lost byte not counted");
	a_stream_next: assert property (push && push_item.last && stream < ctrl.streams_m1
		|=> stream == $past(stream) + 2'h1) else $error("stream did not advance");
	a_proto_pin: assert property (reg_wr && reg_addr == `MP_REG_CTRL
		|=> ##1 long_haul_host_protocol == $past(reg_wdata[2], 2))
		else $error("protocol pin not following control");
	a_clk_half: assert property ($fell(sys_out_clk) |=> !sys_out_clk [*4])
		else $error("output clock low phase too short");
endmodule : sync_bitstream_modem_port

// [sync_bitstream_modem_port_bench.sv]
// Self-checking bench of the modem port
`timescale 1ns/1ns
module sync_bitstream_modem_port_bench;
	import modem_port_pkg::*;
	typedef struct packed {
		logic [7:0]  addr;
		logic        wr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_t;
	localparam row_t ROWS [10] = '{
		'{8'h00, 1'h0, 32'h0, 32'h0}, '{8'h04, 1'h0, 32'h0, 32'h16},
		'{8'h08, 1'h0, 32'h0, 32'h10}, '{8'h10, 1'h0, 32'h0, 32'h0},
		'{8'h14, 1'h0, 32'h0, 32'h0}, '{8'h04, 1'h1, 32'h7E, 32'h7E},
		'{8'h04, 1'h1, 32'h16, 32'h16}, '{8'h14, 1'h1, 32'hFF, 32'h0},
		'{8'h08, 1'h1, 32'h3, 32'h3}, '{8'h00, 1'h1, 32'hD, 32'hD}};
	// Message bytes: {last, stream, data}
	localparam logic [10:0] EXPM [6] = '{11'h041, 11'h042, 11'h443, 11'h144, 11'h116, 11'h545};
	logic        clk;
	logic        rst_b;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        sys_in_clk;
	logic        sys_data_in;
	logic        sys_out_clk;
	logic        sys_data_out;
	net_byte_t   net_tx;
	logic        net_tx_valid;
	logic        net_tx_ready;
	net_byte_t   net_rx;
	logic        net_rx_valid;
	logic        net_rx_ready;
	logic        long_haul_host_protocol;
	net_byte_t   mq[$];
	logic [31:0] d;
	int          fails;
	int          checked;
	int          n;
	int          lowcnt;
	int          maxlow;

	sync_bitstream_modem_port #(.HALF_CYCLES(5), .FIFO_DEPTH(8)) i_dut (.clk(clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_in_clk(sys_in_clk),
		.sys_data_in(sys_data_in), .sys_out_clk(sys_out_clk), .sys_data_out(sys_data_out),
		.net_tx(net_tx), .net_tx_valid(net_tx_valid), .net_tx_ready(net_tx_ready),
		.net_rx(net_rx), .net_rx_valid(net_rx_valid), .net_rx_ready(net_rx_ready),
		.long_haul_host_protocol(long_haul_host_protocol));
	modem_user_model #(.SYN(8'h16)) i_sys (.sys_in_clk(sys_in_clk),
		.sys_data_in(sys_data_in), .sys_out_clk(sys_out_clk), .sys_data_out(sys_data_out));

	// 125 MHz clock
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// Network side taps and input clock low-phase tracker
	always @(posedge clk)
	begin
		if (net_tx_valid === 1'h1 && net_tx_ready === 1'h1)
			mq.push_back(net_tx);
		lowcnt = (sys_in_clk === 1'h0) ? lowcnt + 1 : 0;
		if (lowcnt > maxlow)
			maxlow = lowcnt;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic send_net(input logic [7:0] b);
		@(posedge clk);
		net_rx <= {1'h0, 2'h0, b};
		net_rx_valid <= 1'h1;
		do
			@(posedge clk);
		while (net_rx_ready !== 1'h1);
		net_rx_valid <= 1'h0;
	endtask : send_net
	task automatic end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// Watchdog, far beyond the expected run of about 6500 cycles
	initial
	begin
		#400000;
		fails++;
		end_sim();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst_b = 1'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		net_tx_ready = 1'h1;
		net_rx = 11'h0;
		net_rx_valid = 1'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		#1 chk("reset_outs", 32'({sys_in_clk, sys_out_clk, net_tx_valid, net_rx_ready,
			long_haul_host_protocol}) | reg_rdata, 32'h0);
		@(posedge clk);
		#1 chk("rx_ready", 32'(net_rx_ready), 32'h1);
		foreach (ROWS[i])
		begin
			if (ROWS[i].wr)
				wr(ROWS[i].addr, ROWS[i].wdata);
			rd(ROWS[i].addr, d);
			chk("reg_row", d, ROWS[i].exp);
		end
		chk("long_haul", 32'(long_haul_host_protocol), 32'h1);
		// Output bytes in order between fill characters
		i_sys.rx_q.delete();
		send_net(8'hA5);
		send_net(8'h3C);
		for (n = 0; n < 2000 && i_sys.rx_q.size() < 8; n++) @(posedge clk);
		n = 0;
		while (n < 5 && i_sys.rx_q[n] === 8'h16) n++;
		chk("out_first", 32'(i_sys.rx_q[n]), 32'hA5);
		chk("out_second", 32'(i_sys.rx_q[n + 1]), 32'h3C);
		chk("out_fill", 32'(i_sys.rx_q[n + 2]), 32'h16);
		// Fill off: clock held while starved, resumes on data
		wr(8'h00, 32'hC);
		repeat (200) @(posedge clk);
		n = 0;
		repeat (100)
		begin
			@(posedge clk);
			if (sys_out_clk !== 1'h0) n++;
		end
		chk("out_clk_held", 32'(n), 32'h0);
		i_sys.rx_q.delete();
		send_net(8'h5A);
		for (n = 0; n < 500 && i_sys.rx_q.size() < 1; n++) @(posedge clk);
		chk("out_resume", 32'(i_sys.rx_q[0]), 32'h5A);
		// Two 3-byte messages, fill between them and one fill byte inside
		wr(8'h00, 32'hD);
		mq.delete();
		foreach (EXPM[i]) i_sys.tx_q.push_back(8'h0);
		i_sys.tx_q = '{8'h41, 8'h42, 8'h43, 8'h16, 8'h16, 8'h44, 8'h16, 8'h45};
		for (n = 0; n < 3000 && mq.size() < 6; n++) @(posedge clk);
		foreach (EXPM[i]) chk("msg_byte", 32'(mq[i]), 32'(EXPM[i]));
		// Guaranteed mode: stalled network pauses the input clock
		wr(8'h08, 32'h0);
		wr(8'h00, 32'hA);
		net_tx_ready <= 1'h0;
		mq.delete();
		maxlow = 0;
		for (int i = 0; i < 12; i++) i_sys.tx_q.push_back(8'(8'h60 + i));
		repeat (2000) @(posedge clk);
		chk("in_paused", 32'(maxlow > 20), 32'h1);
		rd(8'h0C, d);
		chk("status", d, 32'h0000090F);
		chk("long_haul_off", 32'(long_haul_host_protocol), 32'h0);
		net_tx_ready <= 1'h1;
		for (n = 0; n < 3000 && mq.size() < 12; n++) @(posedge clk);
		for (int i = 0; i < 12; i++) chk("kept_byte", 32'(mq[i][7:0]), 32'(8'h60 + i));
		rd(8'h10, d);
		chk("no_loss", d, 32'h0);
		// Fixed delay mode: no pause, bytes lost and counted
		wr(8'h00, 32'h9);
		net_tx_ready <= 1'h0;
		maxlow = 0;
		repeat (2000) @(posedge clk);
		chk("no_pause", 32'(maxlow < 12), 32'h1);
		rd(8'h10, d);
		chk("loss_seen", 32'(d != 32'h0), 32'h1);
		net_tx_ready <= 1'h1;
		repeat (300) @(posedge clk);
		wr(8'h10, 32'h0);
		rd(8'h10, d);
		chk("loss_clear", d, 32'h0);
		end_sim();
	end
endmodule : sync_bitstream_modem_port_bench
